//--- rtl/pm_pkg.sv
/*
 * Shared constants and carrier types of the power monitor register map:
 * pointer addresses, field positions, reset values, conversion timing and
 * the result arithmetic divisors.
 * Assumes a single 50 MHz system clock for all timing counts.
 */
package pm_pkg;

    // register pointer addresses
    localparam logic [7:0] PM_PTR_CFG = 8'h00;
    localparam logic [7:0] PM_PTR_SHUNT = 8'h01;
    localparam logic [7:0] PM_PTR_BUS = 8'h02;
    localparam logic [7:0] PM_PTR_PWR = 8'h03;
    localparam logic [7:0] PM_PTR_CUR = 8'h04;
    localparam logic [7:0] PM_PTR_CAL = 8'h05;
    localparam logic [7:0] PM_PTR_MASK = 8'h06;
    localparam logic [7:0] PM_PTR_LIMIT = 8'h07;
    localparam logic [7:0] PM_PTR_MFR = 8'hFE;
    localparam logic [7:0] PM_PTR_DIE = 8'hFF;

    // reset values
    localparam logic [15:0] PM_CFG_RESET = 16'h4127;
    localparam logic [15:0] PM_ZERO_WORD = 16'h0000;

    // configuration fields
    localparam int PM_CFG_RST_BIT = 15;
    localparam int PM_CFG_AVG_LSB = 9;
    localparam int PM_CFG_BCT_LSB = 6;
    localparam int PM_CFG_SCT_LSB = 3;
    localparam int PM_CFG_MODE_LSB = 0;
    localparam int PM_FIELD_W = 3;
    localparam int PM_MODE_SHUNT_BIT = 0;
    localparam int PM_MODE_BUS_BIT = 1;
    localparam int PM_MODE_CONT_BIT = 2;

    // alert select register: flag bits are hardware owned
    localparam int PM_MASK_CONVERSION_READY_FLAG_BIT = 3;
    localparam int PM_MASK_OVF_BIT = 2;
    localparam logic [15:0] PM_MASK_WR = 16'hFFE3;

    // result fields
    localparam int PM_SIGN_BIT = 15;
    localparam int PM_MAG_W = 15;

    // conversion times in ns and in clock cycles
    localparam int unsigned PM_CLK_NS = 20;
    localparam int unsigned PM_CT_NS [0:7] = '{150000, 210000, 332000, 511000,
                                              1036000, 1986000, 3920000, 7736000};
    localparam int unsigned PM_CT_CYC [0:7] = '{
        PM_CT_NS[0] / PM_CLK_NS, PM_CT_NS[1] / PM_CLK_NS,
        PM_CT_NS[2] / PM_CLK_NS, PM_CT_NS[3] / PM_CLK_NS,
        PM_CT_NS[4] / PM_CLK_NS, PM_CT_NS[5] / PM_CLK_NS,
        PM_CT_NS[6] / PM_CLK_NS, PM_CT_NS[7] / PM_CLK_NS};
    localparam int PM_CNT_W = 19;

    // averaging: sample counts 1,4,16,64,128,256,512,1024 as shifts
    localparam int unsigned PM_AVG_SHIFT [0:7] = '{0, 2, 4, 6, 7, 8, 9, 10};
    localparam int PM_AVG_CNT_W = 11;
    localparam int PM_ACC_W = 27;

    // arithmetic divisors
    localparam logic signed [31:0] PM_CUR_DIV = 32'sh00000800;
    localparam logic [31:0] PM_PWR_DIV = 32'h00004E20;

    typedef struct packed {
        logic frameStart;
        logic ptrValid;
        logic wrValid;
        logic rdReq;
        logic [7:0] data;
    } pm_host_t;

    typedef struct packed {
        logic [15:0] shunt;
        logic [14:0] bus;
    } pm_adc_t;

    typedef struct packed {
        logic [15:0] cur;
        logic [15:0] pwr;
        logic ovf;
    } pm_math_t;

endpackage : pm_pkg

//--- rtl/pm_conv_timer.sv
/*
 * Conversion-time counter: loaded with a cycle count, pulses done when it
 * expires. Abort drops a running count without a done pulse.
 * Assumes load and abort come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module pm_conv_timer #(
    parameter int CNT_W = pm_pkg::PM_CNT_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic abort,
    input wire logic [CNT_W-1:0] count,
    output logic done
);
    import pm_pkg::*;

    typedef struct packed {
        logic busy;
        logic done;
        logic [CNT_W-1:0] cnt;
    } pm_tmr_t;

    pm_tmr_t tmr_r;
    pm_tmr_t tmr_nxt;

    always_comb begin
        tmr_nxt = tmr_r;
        tmr_nxt.done = 1'b0;
        if (abort) begin
            tmr_nxt.busy = 1'b0;
            tmr_nxt.cnt = '0;
        end else if (load) begin
            tmr_nxt.busy = 1'b1;
            tmr_nxt.cnt = count;
        end else if (tmr_r.busy) begin
            if (tmr_r.cnt <= CNT_W'(1)) begin
                tmr_nxt.busy = 1'b0;
                tmr_nxt.done = 1'b1;
            end else begin
                tmr_nxt.cnt = tmr_r.cnt - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tmr_r <= '0;
        end else begin
            tmr_r <= tmr_nxt;
        end
    end

    assign done = tmr_r.done;

endmodule : pm_conv_timer
`default_nettype wire

//--- rtl/pm_result_math.sv
/*
 * Per-sample current and power arithmetic, one cycle of latency.
 * Assumes go is a one-cycle pulse with the operands stable in that cycle.
 */
`timescale 1ns/100ps
`default_nettype none
module pm_result_math (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic go,
    input wire logic [15:0] shunt,
    input wire logic [14:0] bus,
    input wire logic [14:0] cal,
    output logic valid,
    output var pm_pkg::pm_math_t res
);
    import pm_pkg::*;

    typedef struct packed {
        logic valid;
        pm_math_t res;
    } pm_mth_t;

    pm_mth_t mth_r;
    pm_mth_t mth_nxt;
    logic signed [31:0] curProd;
    logic signed [31:0] curQuot;
    logic [15:0] curSat;
    logic [16:0] curMag;
    logic [31:0] pwrProd;
    logic [31:0] pwrQuot;
    logic curOvf;

    always_comb begin
        // integer divide truncates toward zero, as software would
        curProd = $signed(shunt) * $signed({1'b0, cal});
        curQuot = curProd / PM_CUR_DIV;
        curOvf = 1'b0;
        if (curQuot > 32'sh00007FFF) begin
            curSat = 16'h7FFF;
            curOvf = 1'b1;
        end else if (curQuot < -32'sh00008000) begin
            curSat = 16'h8000;
            curOvf = 1'b1;
        end else begin
            curSat = curQuot[15:0];
        end
        curMag = curSat[PM_SIGN_BIT] ? 17'(-$signed({curSat[15], curSat})) : {1'b0, curSat};
        // power is never negative, so the current magnitude feeds it
        pwrProd = 32'(curMag) * 32'(bus);
        pwrQuot = pwrProd / PM_PWR_DIV;
        mth_nxt.valid = go;
        mth_nxt.res = mth_r.res;
        if (go) begin
            mth_nxt.res.cur = curSat;
            mth_nxt.res.pwr = pwrQuot[15:0];
            mth_nxt.res.ovf = curOvf;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mth_r <= '0;
        end else begin
            mth_r <= mth_nxt;
        end
    end

    assign valid = mth_r.valid;
    assign res = mth_r.res;

endmodule : pm_result_math
`default_nettype wire

//--- rtl/pm_register_map.sv
/*
 * Register map and measurement sequencer of the power monitor: 16-bit
 * registers moved as byte pairs, conversion sequencing, averaging and
 * result storage.
 * Assumes a serial front end on the same clock that decodes frames into
 * pointer, write-byte and read-byte strobes, and converter samples that
 * are valid on the clock when a conversion time expires.
 */
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - registers are 16 bits, moved as bytes
// - configuration reads have no side effects
// - configuration write restarts sequence with new settings
// - reset bit restores all defaults, self-clears
// - averaging field selects 1 to 1024 samples
// - bus field selects conversion time
// - shunt field selects conversion time, same table
// - mode field: power-down, triggered, continuous
// - shunt result is two's complement
// - shunt result step is 2.5 uV
// - all four results show averaged values
// - bus result step is 1.25 mV
// - bus result top bit reads zero
// - power step is 25 current steps
// - power is current times bus over 20000
// - current is shunt times calibration over 2048
// - zero calibration gives zero current and power
// - two fixed identification words at top
// - pointer byte selects register, MSB first
// - ready flag clears on config write of a shunt or bus mode, or mask read
module pm_register_map #(
    parameter int unsigned CONV_CYCLES [0:7] = pm_pkg::PM_CT_CYC,
    parameter logic [15:0] MFR_ID = 16'h0A5A, // arbitrary value
    parameter logic [15:0] DIE_ID = 16'h05A0 // arbitrary value
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire pm_pkg::pm_host_t host,
    input wire pm_pkg::pm_adc_t adc,
    output logic [7:0] rdByte,
    output logic rdValid,
    output logic conversionReadyFlag,
    output logic convActive
);
    import pm_pkg::*;

    typedef enum logic [2:0] {
        SEQ_START, SEQ_IDLE, SEQ_SH_GO, SEQ_SH_WAIT,
        SEQ_BUS_GO, SEQ_BUS_WAIT, SEQ_MATH_GO, SEQ_MATH_WAIT
    } pm_seq_t;

    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] cal;
        logic [15:0] mask;
        logic [15:0] limit;
        logic [15:0] shuntRes;
        logic [14:0] busRes;
        logic [15:0] pwrRes;
        logic [15:0] curRes;
        logic [7:0] ptr;
        logic wrPhase;
        logic [7:0] wrMsb;
        logic rdPhase;
        logic [15:0] rdWord;
        logic [7:0] rdByte;
        logic rdValid;
        logic conversionReadyFlag;
        logic ovf;
        pm_seq_t seq;
        logic [15:0] shuntSmp;
        logic [14:0] busSmp;
        logic [PM_AVG_CNT_W-1:0] avgCnt;
        logic signed [PM_ACC_W-1:0] accShunt;
        logic [PM_ACC_W-1:0] accBus;
        logic signed [PM_ACC_W-1:0] accCur;
        logic [PM_ACC_W-1:0] accPwr;
    } pm_state_t;

    pm_state_t st_r;
    pm_state_t st_nxt;
    logic timerLoad;
    logic timerAbort;
    logic [PM_CNT_W-1:0] timerCount;
    logic timerDone;
    logic mathGo;
    logic mathValid;
    pm_math_t mathRes;

    ////////////////////////////////////////////////////////////////////////
    pm_conv_timer #(
        .CNT_W(PM_CNT_W)
    ) convTimer (
        .clk(clk),
        .rst_b(rst_b),
        .load(timerLoad),
        .abort(timerAbort),
        .count(timerCount),
        .done(timerDone)
    );

    pm_result_math resultMath (
        .clk(clk),
        .rst_b(rst_b),
        .go(mathGo),
        .shunt(st_r.shuntSmp),
        .bus(st_r.busSmp),
        .cal(st_r.cal[PM_MAG_W-1:0]),
        .valid(mathValid),
        .res(mathRes)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [15:0] rdMux;
        logic [15:0] wrWord;
        logic cfgWrite;
        logic [2:0] mode;
        logic [2:0] newMode;
        logic shuntSel;
        logic busSel;
        pm_seq_t firstGo;
        int unsigned avgShift;
        logic [PM_AVG_CNT_W-1:0] avgLast;
        logic signed [PM_ACC_W-1:0] sumShunt;
        logic [PM_ACC_W-1:0] sumBus;
        logic signed [PM_ACC_W-1:0] sumCur;
        logic [PM_ACC_W-1:0] sumPwr;
        logic signed [PM_ACC_W-1:0] avgShunt;
        logic [PM_ACC_W-1:0] avgBus;
        logic signed [PM_ACC_W-1:0] avgCur;
        logic [PM_ACC_W-1:0] avgPwr;
        rdMux = PM_ZERO_WORD;
        wrWord = PM_ZERO_WORD;
        cfgWrite = 1'b0;
        st_nxt = st_r;
        st_nxt.rdValid = 1'b0;
        timerLoad = 1'b0;
        timerAbort = 1'b0;
        timerCount = '0;
        mathGo = 1'b0;
        mode = st_r.cfg[PM_CFG_MODE_LSB +: PM_FIELD_W];
        shuntSel = mode[PM_MODE_SHUNT_BIT];
        busSel = mode[PM_MODE_BUS_BIT];
        firstGo = shuntSel ? SEQ_SH_GO : SEQ_BUS_GO;
        avgShift = PM_AVG_SHIFT[st_r.cfg[PM_CFG_AVG_LSB +: PM_FIELD_W]];
        avgLast = PM_AVG_CNT_W'((1 << avgShift) - 1);
        sumShunt = st_r.accShunt + PM_ACC_W'($signed(st_r.shuntSmp));
        sumBus = st_r.accBus + PM_ACC_W'(st_r.busSmp);
        sumCur = st_r.accCur + PM_ACC_W'($signed(mathRes.cur));
        sumPwr = st_r.accPwr + PM_ACC_W'(mathRes.pwr);
        avgShunt = sumShunt >>> avgShift;
        avgBus = sumBus >> avgShift;
        avgCur = sumCur >>> avgShift;
        avgPwr = sumPwr >> avgShift;

        // read mux: side-effect free except for the alert select register
        case (st_r.ptr)
            PM_PTR_CFG: rdMux = st_r.cfg;
            PM_PTR_SHUNT: rdMux = st_r.shuntRes;
            PM_PTR_BUS: rdMux = {1'b0, st_r.busRes};
            PM_PTR_PWR: rdMux = st_r.pwrRes;
            PM_PTR_CUR: rdMux = st_r.curRes;
            PM_PTR_CAL: rdMux = st_r.cal;
            PM_PTR_MASK: begin
                rdMux = st_r.mask;
                rdMux[PM_MASK_CONVERSION_READY_FLAG_BIT] = st_r.conversionReadyFlag;
                rdMux[PM_MASK_OVF_BIT] = st_r.ovf;
            end
            PM_PTR_LIMIT: rdMux = st_r.limit;
            PM_PTR_MFR: rdMux = MFR_ID;
            PM_PTR_DIE: rdMux = DIE_ID;
            default: rdMux = PM_ZERO_WORD;
        endcase

        ////////////////////////////////////////////////////////////////////
        if (host.frameStart) begin
            st_nxt.wrPhase = 1'b0;
            st_nxt.rdPhase = 1'b0;
        end
        if (host.ptrValid) begin
            st_nxt.ptr = host.data;
            st_nxt.wrPhase = 1'b0;
            st_nxt.rdPhase = 1'b0;
        end else if (host.wrValid) begin
            if (!st_r.wrPhase) begin
                st_nxt.wrMsb = host.data;
                st_nxt.wrPhase = 1'b1;
            end else begin
                st_nxt.wrPhase = 1'b0;
                wrWord = {st_r.wrMsb, host.data};
                case (st_r.ptr)
                    PM_PTR_CFG: begin
                        st_nxt.cfg = wrWord;
                        cfgWrite = 1'b1;
                    end
                    PM_PTR_CAL: st_nxt.cal = wrWord;
                    PM_PTR_MASK: st_nxt.mask = wrWord & PM_MASK_WR;
                    PM_PTR_LIMIT: st_nxt.limit = wrWord;
                    default: st_nxt.cal = st_r.cal;
                endcase
            end
        end else if (host.rdReq) begin
            st_nxt.rdValid = 1'b1;
            if (!st_r.rdPhase) begin
                // whole word captured so both bytes belong together
                st_nxt.rdWord = rdMux;
                st_nxt.rdByte = rdMux[15:8];
                st_nxt.rdPhase = 1'b1;
                if (st_r.ptr == PM_PTR_MASK) begin
                    st_nxt.conversionReadyFlag = 1'b0;
                    st_nxt.ovf = 1'b0;
                end
            end else begin
                st_nxt.rdByte = st_r.rdWord[7:0];
                st_nxt.rdPhase = 1'b0;
            end
        end

        ////////////////////////////////////////////////////////////////////
        newMode = wrWord[PM_CFG_MODE_LSB +: PM_FIELD_W];
        if (cfgWrite) begin
            st_nxt.seq = SEQ_START;
            timerAbort = 1'b1;
            if (newMode[PM_MODE_SHUNT_BIT] || newMode[PM_MODE_BUS_BIT]) begin
                st_nxt.conversionReadyFlag = 1'b0;
            end
        end else begin
            case (st_r.seq)
                SEQ_START: begin
                    st_nxt.accShunt = '0;
                    st_nxt.accBus = '0;
                    st_nxt.accCur = '0;
                    st_nxt.accPwr = '0;
                    st_nxt.avgCnt = '0;
                    st_nxt.seq = (shuntSel || busSel) ? firstGo : SEQ_IDLE;
                end
                SEQ_IDLE: st_nxt.seq = SEQ_IDLE;
                SEQ_SH_GO: begin
                    timerLoad = 1'b1;
                    timerCount = PM_CNT_W'(CONV_CYCLES[st_r.cfg[PM_CFG_SCT_LSB +: PM_FIELD_W]]);
                    st_nxt.seq = SEQ_SH_WAIT;
                end
                SEQ_SH_WAIT: begin
                    if (timerDone) begin
                        st_nxt.shuntSmp = adc.shunt;
                        st_nxt.seq = busSel ? SEQ_BUS_GO : SEQ_MATH_GO;
                    end
                end
                SEQ_BUS_GO: begin
                    timerLoad = 1'b1;
                    timerCount = PM_CNT_W'(CONV_CYCLES[st_r.cfg[PM_CFG_BCT_LSB +: PM_FIELD_W]]);
                    st_nxt.seq = SEQ_BUS_WAIT;
                end
                SEQ_BUS_WAIT: begin
                    if (timerDone) begin
                        st_nxt.busSmp = adc.bus;
                        st_nxt.seq = SEQ_MATH_GO;
                    end
                end
                SEQ_MATH_GO: begin
                    mathGo = 1'b1;
                    st_nxt.seq = SEQ_MATH_WAIT;
                end
                SEQ_MATH_WAIT: begin
                    if (mathValid) begin
                        if (mathRes.ovf) begin
                            st_nxt.ovf = 1'b1;
                        end
                        if (st_r.avgCnt == avgLast) begin
                            st_nxt.shuntRes = avgShunt[15:0];
                            st_nxt.busRes = avgBus[PM_MAG_W-1:0];
                            st_nxt.curRes = avgCur[15:0];
                            st_nxt.pwrRes = avgPwr[15:0];
                            // set after the read clear, so a same-cycle set wins
                            st_nxt.conversionReadyFlag = 1'b1;
                            st_nxt.accShunt = '0;
                            st_nxt.accBus = '0;
                            st_nxt.accCur = '0;
                            st_nxt.accPwr = '0;
                            st_nxt.avgCnt = '0;
                            st_nxt.seq = mode[PM_MODE_CONT_BIT] ? firstGo : SEQ_IDLE;
                        end else begin
                            st_nxt.accShunt = sumShunt;
                            st_nxt.accBus = sumBus;
                            st_nxt.accCur = sumCur;
                            st_nxt.accPwr = sumPwr;
                            st_nxt.avgCnt = st_r.avgCnt + PM_AVG_CNT_W'(1);
                            st_nxt.seq = firstGo;
                        end
                    end
                end
                default: st_nxt.seq = SEQ_START;
            endcase
        end

        // soft reset: everything back to power-on values, bit not stored
        if (cfgWrite && wrWord[PM_CFG_RST_BIT]) begin
            st_nxt = '0;
            st_nxt.cfg = PM_CFG_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.cfg <= PM_CFG_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdByte = st_r.rdByte;
    assign rdValid = st_r.rdValid;
    assign conversionReadyFlag = st_r.conversionReadyFlag;
    assign convActive = (st_r.seq != SEQ_IDLE);

endmodule : pm_register_map
`default_nettype wire

//--- bench/pm_register_map_chk.sv
/* Port checker of the power monitor register map, bound to its top.
   Assumes one clock, synchronous active-low reset, byte strobes on host. */
`timescale 1ns/100ps
`default_nettype none
module pm_register_map_chk (
    input wire logic clk,
    input wire logic rst_b,
    input wire pm_pkg::pm_host_t host,
    input wire pm_pkg::pm_adc_t adc,
    input wire logic [7:0] rdByte,
    input wire logic rdValid,
    input wire logic conversionReadyFlag,
    input wire logic convActive
);
    import pm_pkg::*;
    logic [7:0] ptr_r;
    logic wph_r;
    logic rph_r;
    logic msb7_r;
    logic wrAcc;
    logic rdAcc;
    logic commit;
    logic maskRd;
    assign wrAcc = host.wrValid && !host.ptrValid;
    assign rdAcc = host.rdReq && !host.ptrValid && !host.wrValid;
    assign commit = wrAcc && wph_r && ptr_r == PM_PTR_CFG;
    assign maskRd = rdAcc && !rph_r && ptr_r == PM_PTR_MASK;
    // shadow of pointer and byte phases, kept from the strobes alone
    always_ff @(posedge clk) begin
        if (!rst_b || host.frameStart || host.ptrValid) begin
            wph_r <= 1'b0;
            rph_r <= 1'b0;
        end else begin
            wph_r <= wph_r ^ wrAcc;
            rph_r <= rph_r ^ rdAcc;
        end
        if (!rst_b) begin
            ptr_r <= 8'h00;
        end else if (host.ptrValid) begin
            ptr_r <= host.data;
        end
        if (wrAcc && !wph_r) begin
            msb7_r <= host.data[7];
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_read_answer: assert property (rdAcc |=> rdValid)
        else $error("read byte not answered");
    a_answer_cause: assert property (rdValid |-> $past(rdAcc))
        else $error("read answer without request");
    // a soft reset clears the held byte like a power-on reset
    a_byte_held: assert property (!rdValid |-> $stable(rdByte)
        || ($past(commit && msb7_r) && rdByte == 8'h00))
        else $error("read byte moved between answers");
    a_reset_state: assert property ($rose(rst_b) |-> convActive && !conversionReadyFlag)
        else $error("wrong state after reset");
    a_cfg_restart: assert property (commit && host.data[1:0] != 2'b00
        |=> convActive && !conversionReadyFlag) else $error("no restart on write");
    // one start cycle passes before the sequencer settles idle
    a_pwrdown_hold: assert property (commit && host.data[1:0] == 2'b00 && !msb7_r
        |=> $stable(conversionReadyFlag) ##1 !convActive && $stable(conversionReadyFlag))
        else $error("power-down wrong");
    a_mask_clear: assert property (maskRd && !convActive |=> !conversionReadyFlag)
        else $error("flag kept after mask read");
    a_idle_quiet: assert property (!convActive && !commit && !maskRd
        |=> !convActive && $stable(conversionReadyFlag)) else $error("idle not quiet");
    a_flag_source: assert property ($rose(conversionReadyFlag) |-> $past(convActive))
        else $error("flag set while idle");
    cover property (maskRd && !convActive);
    cover property ($fell(convActive));
    cover property (commit && msb7_r);
endmodule : pm_register_map_chk
bind pm_register_map pm_register_map_chk u_chk (.clk(clk), .rst_b(rst_b), .host(host),
    .adc(adc), .rdByte(rdByte), .rdValid(rdValid),
    .conversionReadyFlag(conversionReadyFlag), .convActive(convActive));
`default_nettype wire

//--- bench/pm_host_model.sv
/* Bus master side: turns register reads and writes into byte strobes.
   Assumes the map answers a read byte one clock after the request. */
`timescale 1ns/100ps
`default_nettype none
module pm_host_model (
    input wire logic clk,
    input wire logic [7:0] rdByte,
    input wire logic rdValid,
    output var pm_pkg::pm_host_t host
);
    import pm_pkg::*;
    int nMiss = 0;
    initial host = '0;
    task automatic pulse(input logic [3:0] k, input logic [7:0] d);
        @(posedge clk);
        host <= {k, d};
        @(posedge clk);
        // released data is scrambled, not a held copy
        host <= {4'h0, ~d};
    endtask : pulse
    task automatic write_reg(input logic [7:0] p, input logic [15:0] v);
        pulse(4'h8, 8'h00);
        pulse(4'h4, p);
        pulse(4'h2, v[15:8]);
        pulse(4'h2, v[7:0]);
    endtask : write_reg
    task automatic read_reg(input logic [7:0] p, input bit newPtr, output logic [15:0] v);
        pulse(4'h8, 8'h00);
        if (newPtr) pulse(4'h4, p);
        for (int i = 1; i >= 0; i--) begin
            pulse(4'h1, 8'h00);
            @(posedge clk);
            if (rdValid !== 1'b1) nMiss++;
            v[i*8 +: 8] = rdByte;
        end
    endtask : read_reg
endmodule : pm_host_model
`default_nettype wire

//--- bench/power_monitor_register_map_test.sv
/* Self-checking bench of the power monitor register map.
   Assumes the host model drives every strobe and the bench drives samples. */
`timescale 1ns/100ps
`default_nettype none
module power_monitor_register_map_test;
    import pm_pkg::*;
    localparam logic [15:0] MFR = 16'h0A5A; // arbitrary value
    localparam logic [15:0] DIE = 16'h05A0; // arbitrary value
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    pm_host_t host;
    pm_adc_t adc = '0;
    logic [7:0] rdByte;
    logic rdValid;
    logic conversionReadyFlag;
    logic convActive;
    logic [15:0] w;
    int n_mismatch = 0;
    int tests_run = 0;
    int cur;
    int pwr;
    // first results land during these reads, but samples are zero so results stay zero
    logic [7:0] rowPtr [11] = '{8'h06, 8'h01, 8'h02, 8'h03, 8'h04, 8'h00, 8'h05, 8'h07,
        8'hFE, 8'hFF, 8'h08};
    logic [15:0] rowExp [11] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h4127, 16'h0000, 16'h0000, MFR, DIE, 16'h0000};

    initial forever #10 clk = ~clk;
    // short conversion times keep the run brief
    pm_register_map #(.CONV_CYCLES('{20, 21, 22, 23, 24, 25, 26, 27}), .MFR_ID(MFR),
        .DIE_ID(DIE)) uut (.clk(clk), .rst_b(rst_b), .host(host), .adc(adc),
        .rdByte(rdByte), .rdValid(rdValid), .conversionReadyFlag(conversionReadyFlag),
        .convActive(convActive));
    pm_host_model hm (.clk(clk), .rdByte(rdByte), .rdValid(rdValid), .host(host));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rd(input logic [7:0] p, input logic [15:0] e);
        hm.read_reg(p, 1'b1, w);
        check($sformatf("reg %h", p), w, e);
    endtask : rd
    // level is taken at the falling edge, not when the call is made
    task automatic lvl(input string what, input logic exp);
        logic seen;
        @(negedge clk);
        seen = (what == "active") ? convActive : conversionReadyFlag;
        check(what, {15'h0000, seen}, {15'h0000, exp});
    endtask : lvl
    task automatic wait_flag();
        // let the committing write land before the flag is looked at
        @(posedge clk);
        for (int i = 0; i < 400 && conversionReadyFlag !== 1'b1; i++) @(posedge clk);
        lvl("ready", 1'b1);
    endtask : wait_flag
    task automatic give_verdict();
        n_mismatch += hm.nMiss;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        lvl("ready", 1'b0);
        lvl("active", 1'b1);
        for (int i = 0; i < 11; i++) rd(rowPtr[i], rowExp[i]);
        hm.write_reg(8'h01, 16'hABCD);
        hm.write_reg(8'hFE, 16'hABCD);
        hm.write_reg(8'h07, 16'hABCD);
        rd(8'h01, 16'h0000);
        rd(8'hFE, MFR);
        rd(8'h07, 16'hABCD);
        hm.read_reg(8'h00, 1'b0, w);
        check("reread", w, 16'hABCD);
        // negative shunt, both channels triggered, fastest times
        @(posedge clk);
        adc <= '{16'h8300, 15'h1F40};
        hm.write_reg(8'h05, 16'h03E8);
        hm.write_reg(8'h00, 16'h4003);
        wait_flag();
        lvl("active", 1'b0);
        cur = (-32000 * 1000) / 2048;
        pwr = ((cur < 0 ? -cur : cur) * 8000) / 20000;
        rd(8'h01, 16'h8300);
        rd(8'h02, 16'h1F40);
        rd(8'h04, 16'(cur));
        rd(8'h03, 16'(pwr));
        rd(8'h00, 16'h4003);
        lvl("ready", 1'b1);
        rd(8'h06, 16'h0008);
        lvl("ready", 1'b0);
        // four samples take far longer than one
        hm.write_reg(8'h00, 16'h4203);
        repeat (80) @(posedge clk);
        lvl("ready", 1'b0);
        wait_flag();
        rd(8'h04, 16'(cur));
        hm.write_reg(8'h00, 16'h8000);
        wait_flag();
        rd(8'h00, 16'h4127);
        rd(8'h05, 16'h0000);
        rd(8'h04, 16'h0000);
        rd(8'h03, 16'h0000);
        rd(8'h01, 16'h8300);
        hm.write_reg(8'h00, 16'h4000);
        lvl("ready", 1'b1);
        lvl("active", 1'b0);
        for (int m = 0; m < 8; m++) begin
            hm.write_reg(8'h00, 16'h4000 | 16'(m));
            // one clock past the restart cycle, so power-down already shows idle
            @(posedge clk);
            lvl("active", m % 4 != 0);
        end
        give_verdict();
    end
endmodule : power_monitor_register_map_test
`default_nettype wire
